//--- inc/rcg_defs.svh
// Constants for the reset and core glue block
`ifndef RCG_DEFS_SVH
`define RCG_DEFS_SVH

`define RCG_CLK_MHZ         100
`define RCG_COLD_MIN_US     700
`define RCG_COLD_MIN_CYC    (`RCG_COLD_MIN_US * `RCG_CLK_MHZ)
`define RCG_WARM_MIN_CYC    4'hc
`define RCG_CNT_W           4
`define RCG_IRQ_NUM         50
`define RCG_INTLINES_W      5
`define RCG_INTLINES_VAL    5'h01
`define RCG_PRIO_BITS_W     4
`define RCG_PRIO_BITS_VAL   4'h3
`define RCG_AFSR_VAL        32'h0000_0000
`define RCG_DBG_PINS        5
`define RCG_DBG_RST_VAL     5'h1f
`define RCG_TRACE_PINS      5
`define RCG_TRACE_RST_VAL   5'h00
`define RCG_DBG_PORT_A_BIT_ZERO 0
`define RCG_DBG_PORT_B_BIT_ZERO 2

`endif

//--- inc/rcg_if.sv
// Link between the glue device and the board and core
`timescale 1ns/1ns
`default_nettype none
`include "rcg_defs.svh"
interface rcg_if;
    logic                      ext_reset_n;
    logic                      core_system_reset_request;
    logic                      core_halted_fault_out;
    logic                      core_event_out;
    logic                      deep_sleep_flag;
    logic                      core_excl_req;
    logic                      sys_reset_n;
    logic                      core_event_in;
    logic                      core_excl_okay;
    logic [`RCG_IRQ_NUM-1:0]   core_irq;

    modport dev (
        input  ext_reset_n, core_system_reset_request, core_halted_fault_out,
        input  core_event_out, deep_sleep_flag, core_excl_req,
        output sys_reset_n, core_event_in, core_excl_okay, core_irq
    );
    modport brd (
        output ext_reset_n, core_system_reset_request, core_halted_fault_out,
        output core_event_out, deep_sleep_flag, core_excl_req,
        input  sys_reset_n, core_event_in, core_excl_okay, core_irq
    );
endinterface
`default_nettype wire

//--- inc/rcg_pkg.sv
// Types shared by both ends of the reset and core glue
package rcg_pkg;
    typedef enum logic [1:0] {
        RCG_ST_COLD = 2'h0,
        RCG_ST_RUN  = 2'h1,
        RCG_ST_WARM = 2'h2
    } rcg_dev_state_type;

    typedef enum logic [1:0] {
        RCG_BS_PWR  = 2'h0,
        RCG_BS_COLD = 2'h1,
        RCG_BS_RUN  = 2'h2,
        RCG_BS_WARM = 2'h3
    } rcg_brd_state_type;
endpackage

//--- rtl/rcg_board.sv
// Board and core end: reset pin sequencing and core outputs
`timescale 1ns/1ns
`default_nettype none
`include "rcg_defs.svh"
module rcg_board #(
    parameter int COLD_HOLD_CYC = `RCG_COLD_MIN_CYC
) (
    // Clock and reset
    input  wire logic    clk,
    input  wire logic    rstn,
    // Link to the device
    rcg_if.brd           lnk,
    // Board controls
    input  wire logic    power_good,
    input  wire logic    button_reset,
    input  wire logic    sw_reset_req,
    input  wire logic    slow_mode,
    input  wire logic    core_core_halted_fault_out,
    // Status
    output logic         pin_low,
    output logic         req_refused
);
    rcg_pkg::rcg_brd_state_type    state_ff;
    logic [31:0]                   cnt_ff;
    logic                          pin_n_ff;
    logic                          req_ff;
    logic                          refused_ff;
    logic                          core_halted_fault_out_ff;

    // Pin held low through power-up, cold hold, and warm pulses
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= rcg_pkg::RCG_BS_PWR;
            cnt_ff   <= '0;
            pin_n_ff <= 1'b0;
        end else begin
            case (state_ff)
                rcg_pkg::RCG_BS_PWR: begin
                    pin_n_ff <= 1'b0;
                    cnt_ff   <= '0;
                    if (power_good) begin
                        state_ff <= rcg_pkg::RCG_BS_COLD;
                    end
                end
                rcg_pkg::RCG_BS_COLD: begin
                    // Supply dip restarts the whole hold
                    if (!power_good) begin
                        state_ff <= rcg_pkg::RCG_BS_PWR;
                    end else if (cnt_ff >= 32'(COLD_HOLD_CYC - 1)) begin
                        pin_n_ff <= 1'b1;
                        state_ff <= rcg_pkg::RCG_BS_RUN;
                    end else begin
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                rcg_pkg::RCG_BS_RUN: begin
                    cnt_ff <= '0;
                    if (!power_good) begin
                        pin_n_ff <= 1'b0;
                        state_ff <= rcg_pkg::RCG_BS_PWR;
                    end else if (button_reset) begin
                        pin_n_ff <= 1'b0;
                        state_ff <= rcg_pkg::RCG_BS_WARM;
                    end
                end
                rcg_pkg::RCG_BS_WARM: begin
                    if (cnt_ff >= 32'(`RCG_WARM_MIN_CYC - 4'h1)) begin
                        pin_n_ff <= 1'b1;
                        state_ff <= rcg_pkg::RCG_BS_RUN;
                    end else begin
                        cnt_ff <= cnt_ff + 32'h1;
                    end
                end
                default: begin
                    state_ff <= rcg_pkg::RCG_BS_PWR;
                end
            endcase
        end
    end

    // Core request held until the device takes the core down
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            req_ff     <= 1'b0;
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= sw_reset_req & slow_mode;
            if (!lnk.sys_reset_n) begin
                req_ff <= 1'b0;
            end else if (sw_reset_req && !slow_mode) begin
                req_ff <= 1'b1;
            end
        end
    end

    // Halted-fault output registered through to the device; the other unused core outputs are tied low below
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            core_halted_fault_out_ff <= 1'b0;
        end else begin
            core_halted_fault_out_ff <= core_core_halted_fault_out;
        end
    end

    assign lnk.ext_reset_n               = pin_n_ff;
    assign lnk.core_system_reset_request = req_ff;
    assign lnk.core_halted_fault_out     = core_halted_fault_out_ff;
    assign lnk.core_event_out            = 1'b0;
    assign lnk.deep_sleep_flag           = 1'b0;
    assign lnk.core_excl_req             = 1'b0;
    assign pin_low                       = ~pin_n_ff;
    assign req_refused                   = refused_ff;
endmodule
`default_nettype wire

//--- rtl/rcg_device.sv
// Device end: reset merging, core tie-offs and debug pin setup
//
// Operation
// - Any of pin, watchdog, core request resets
// - Core reset request runs normal system reset
// - Software avoids core reset request in slow
// - Pin low twelve clocks is valid reset
// - Cold reset pin low over 700 us
// - Pin held low until supplies stable
// - Halted-fault output unused; causes no reset
// - Auxiliary fault status always reads zero
// - Fifty interrupt lines; line count reads 00001
// - Three interrupt priority bits configured
// - Event signals unused; no event instructions
// - Deep-sleep output ignored; never set it
// - No exclusive access on data-code bus
// - Five debug pins after reset; trace off
// - Debug data pins stay driven in stop
// - Fault region: memory fault or hard fault
// - Cold-only state skipped by warm reset
// - PLL inactive after any reset until enabled
`timescale 1ns/1ns
`default_nettype none
`include "rcg_defs.svh"
module rcg_device (
    // Clock and power-on reset
    input  wire logic                          clk,
    input  wire logic                          rstn,
    // Link to board and core
    rcg_if.dev                                 lnk,
    // Other reset source
    input  wire logic                          wdt_reset_req,
    // Interrupt sources
    input  wire logic [`RCG_IRQ_NUM-1:0]       irq_src,
    // Software writes
    input  wire logic                          pll_enable_wr,
    input  wire logic                          pll_enable_val,
    input  wire logic                          port_func_wr,
    input  wire logic [`RCG_DBG_PINS-1:0]      dbg_func_val,
    input  wire logic [`RCG_TRACE_PINS-1:0]    trace_func_val,
    input  wire logic                          standby_drive_enable,
    input  wire logic                          stop_mode,
    input  wire logic                          cold_flag_clr,
    // Fault region access
    input  wire logic                          fault_region_access,
    input  wire logic                          mem_fault_enable,
    // Readbacks and status
    output logic [31:0]                        aux_fault_status,
    output logic [`RCG_INTLINES_W-1:0]         interrupt_line_count_field,
    output logic [`RCG_PRIO_BITS_W-1:0]        prio_bits,
    output logic                               in_reset,
    output logic                               cold_init,
    output logic                               clkgen_reset_flag,
    output logic                               pll_active,
    output logic [`RCG_DBG_PINS-1:0]           dbg_func,
    output logic [`RCG_TRACE_PINS-1:0]         trace_func,
    output logic [`RCG_DBG_PINS-1:0]           dbg_pin_oe,
    output logic                               mem_fault,
    output logic                               hard_fault
);
    logic                          pin_s1_ff;
    logic                          pin_s2_ff;
    logic [`RCG_CNT_W-1:0]         low_cnt_ff;
    logic [`RCG_CNT_W-1:0]         nxt_low_cnt;
    logic                          pin_valid;
    logic                          src_active;
    rcg_pkg::rcg_dev_state_type    state_ff;
    rcg_pkg::rcg_dev_state_type    nxt_state;
    logic                          sys_reset_n_ff;
    logic                          in_reset_ff;
    logic                          cold_init_ff;
    logic                          clkgen_flag_ff;
    logic                          pll_active_ff;
    logic [`RCG_DBG_PINS-1:0]      dbg_func_ff;
    logic [`RCG_TRACE_PINS-1:0]    trace_func_ff;
    logic [`RCG_DBG_PINS-1:0]      dbg_oe_ff;
    logic [`RCG_DBG_PINS-1:0]      nxt_dbg_oe;
    logic                          mem_fault_ff;
    logic                          hard_fault_ff;
    logic [`RCG_IRQ_NUM-1:0]       irq_ff;
    logic                          warm;

    // Pin synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= lnk.ext_reset_n;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Saturating count of consecutive low samples
    always_comb begin
        if (pin_s2_ff) begin
            nxt_low_cnt = '0;
        end else if (low_cnt_ff != `RCG_WARM_MIN_CYC) begin
            nxt_low_cnt = low_cnt_ff + 4'h1;
        end else begin
            nxt_low_cnt = low_cnt_ff;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            low_cnt_ff <= '0;
        end else begin
            low_cnt_ff <= nxt_low_cnt;
        end
    end

    // Shorter glitches are filtered out rather than half-resetting
    assign pin_valid  = (low_cnt_ff == `RCG_WARM_MIN_CYC);
    // Halted-fault output deliberately absent from this term
    assign src_active = pin_valid | wdt_reset_req | lnk.core_system_reset_request;
    assign warm       = (state_ff == rcg_pkg::RCG_ST_WARM);

    // Reset sequencing; release only once all sources are quiet
    always_comb begin
        case (state_ff)
            rcg_pkg::RCG_ST_COLD: begin
                // Pin counts as low until the synchroniser has seen it high
                if (!src_active && pin_s2_ff) begin
                    nxt_state = rcg_pkg::RCG_ST_RUN;
                end else begin
                    nxt_state = rcg_pkg::RCG_ST_WARM;
                end
            end
            rcg_pkg::RCG_ST_RUN: begin
                nxt_state = src_active ? rcg_pkg::RCG_ST_WARM : rcg_pkg::RCG_ST_RUN;
            end
            rcg_pkg::RCG_ST_WARM: begin
                if (!src_active && pin_s2_ff) begin
                    nxt_state = rcg_pkg::RCG_ST_RUN;
                end else begin
                    nxt_state = rcg_pkg::RCG_ST_WARM;
                end
            end
            default: begin
                nxt_state = rcg_pkg::RCG_ST_COLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= rcg_pkg::RCG_ST_COLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // System reset output to the core
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sys_reset_n_ff <= 1'b0;
            in_reset_ff    <= 1'b1;
        end else begin
            sys_reset_n_ff <= (nxt_state == rcg_pkg::RCG_ST_RUN);
            in_reset_ff    <= (nxt_state != rcg_pkg::RCG_ST_RUN);
        end
    end

    // Cold-only state: untouched by warm reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cold_init_ff   <= 1'b0;
            clkgen_flag_ff <= 1'b1;
        end else begin
            cold_init_ff <= (state_ff == rcg_pkg::RCG_ST_COLD);
            if (cold_flag_clr) begin
                clkgen_flag_ff <= 1'b0;
            end
        end
    end

    // PLL stays off after any reset until software turns it on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pll_active_ff <= 1'b0;
        end else if (warm) begin
            pll_active_ff <= 1'b0;
        end else if (pll_enable_wr) begin
            pll_active_ff <= pll_enable_val;
        end
    end

    // Pin functions: debug on after reset, trace only on request
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dbg_func_ff   <= `RCG_DBG_RST_VAL;
            trace_func_ff <= `RCG_TRACE_RST_VAL;
        end else if (warm) begin
            dbg_func_ff   <= `RCG_DBG_RST_VAL;
            trace_func_ff <= `RCG_TRACE_RST_VAL;
        end else if (port_func_wr) begin
            dbg_func_ff   <= dbg_func_val;
            trace_func_ff <= trace_func_val;
        end
    end

    // Stop mode drive: debug data pins ignore the standby enable
    always_comb begin
        nxt_dbg_oe = dbg_func_ff;
        if (stop_mode && !standby_drive_enable) begin
            nxt_dbg_oe = '0;
            nxt_dbg_oe[`RCG_DBG_PORT_A_BIT_ZERO] = dbg_func_ff[`RCG_DBG_PORT_A_BIT_ZERO];
            nxt_dbg_oe[`RCG_DBG_PORT_B_BIT_ZERO] = dbg_func_ff[`RCG_DBG_PORT_B_BIT_ZERO];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dbg_oe_ff <= '0;
        end else begin
            dbg_oe_ff <= nxt_dbg_oe;
        end
    end

    // Fault region access routing, registered one cycle late
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_fault_ff  <= 1'b0;
            hard_fault_ff <= 1'b0;
        end else begin
            mem_fault_ff  <= fault_region_access & mem_fault_enable;
            hard_fault_ff <= fault_region_access & ~mem_fault_enable;
        end
    end

    // Interrupt lines registered to keep core inputs glitch free
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= '0;
        end else begin
            irq_ff <= irq_src;
        end
    end

    // Fixed configuration readbacks and core tie-offs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            aux_fault_status           <= `RCG_AFSR_VAL;
            interrupt_line_count_field <= `RCG_INTLINES_VAL;
            prio_bits                  <= `RCG_PRIO_BITS_VAL;
            lnk.core_event_in          <= 1'b0;
            lnk.core_excl_okay         <= 1'b0;
        end else begin
            aux_fault_status           <= `RCG_AFSR_VAL;
            interrupt_line_count_field <= `RCG_INTLINES_VAL;
            prio_bits                  <= `RCG_PRIO_BITS_VAL;
            // Event output and deep-sleep flag are never looked at
            lnk.core_event_in          <= 1'b0;
            lnk.core_excl_okay         <= 1'b0;
        end
    end

    assign lnk.sys_reset_n     = sys_reset_n_ff;
    assign lnk.core_irq        = irq_ff;
    assign in_reset            = in_reset_ff;
    assign cold_init           = cold_init_ff;
    assign clkgen_reset_flag   = clkgen_flag_ff;
    assign pll_active          = pll_active_ff;
    assign dbg_func            = dbg_func_ff;
    assign trace_func          = trace_func_ff;
    assign dbg_pin_oe          = dbg_oe_ff;
    assign mem_fault           = mem_fault_ff;
    assign hard_fault          = hard_fault_ff;
endmodule
`default_nettype wire

//--- tb/rcg_monitor.sv
// Concurrent checks on the link joining the glue device and the board
`timescale 1ns/1ns
`default_nettype none
`include "rcg_defs.svh"
module rcg_monitor #(
    parameter int COLD_HOLD_CYC = `RCG_COLD_MIN_CYC
) (
    // Clock and reset
    input wire logic                    clk,
    input wire logic                    rstn,
    // Board to device
    input wire logic                    ext_reset_n,
    input wire logic                    core_system_reset_request,
    input wire logic                    core_halted_fault_out,
    input wire logic                    core_event_out,
    input wire logic                    deep_sleep_flag,
    input wire logic                    core_excl_req,
    // Device to core
    input wire logic                    sys_reset_n,
    input wire logic                    core_event_in,
    input wire logic                    core_excl_okay,
    input wire logic [`RCG_IRQ_NUM-1:0] core_irq
);
    logic [4:0]  pin_low_ff;
    logic [31:0] up_ff;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Raw pin low run length, saturating so long holds never wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            pin_low_ff <= 5'h00;
        else if (ext_reset_n)
            pin_low_ff <= 5'h00;
        else if (pin_low_ff != 5'h1f)
            pin_low_ff <= pin_low_ff + 5'h01;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            up_ff <= 32'h0000_0000;
        else
            up_ff <= up_ff + 32'h0000_0001;
    end

    // Pin let go after exactly the minimum warm width
    sequence min_low_s;
        $rose(ext_reset_n) && pin_low_ff == 5'h0c;
    endsequence
    sequence sys_drop_s;
        ##[0:4] !sys_reset_n;
    endsequence

    pin_accept_a:
        assert property (min_low_s |-> sys_drop_s) else $error("minimum pin low not taken as reset");
    long_low_a:
        assert property (pin_low_ff == 5'h10 |-> !sys_reset_n) else $error("long pin low without reset");
    release_a:
        assert property ($rose(sys_reset_n) |-> $past(ext_reset_n, 2) && !core_system_reset_request)
        else $error("reset released while a source was active");
    req_reset_a:
        assert property (core_system_reset_request |=> !sys_reset_n) else $error("core request gave no reset");
    req_drop_a:
        assert property (core_system_reset_request && !sys_reset_n |-> ##[1:2] !core_system_reset_request)
        else $error("core request held after reset seen");
    halt_ignore_a:
        assert property (core_halted_fault_out && sys_reset_n && ext_reset_n && !core_system_reset_request
                         |=> sys_reset_n) else $error("halted fault caused a reset");
    event_tie_a:
        assert property (!core_event_in) else $error("event input to core not tied low");
    excl_tie_a:
        assert property (!core_excl_okay) else $error("exclusive access granted");
    board_tie_a:
        assert property (!core_event_out && !deep_sleep_flag && !core_excl_req) else $error("core tie-off raised");
    cold_hold_a:
        assert property (up_ff < COLD_HOLD_CYC |-> !ext_reset_n) else $error("pin released before cold hold");
endmodule
`default_nettype wire

//--- tb/reset_and_core_glue_test.sv
// Self-checking bench joining the glue device and board ends
`timescale 1ns/1ns
`default_nettype none
`include "rcg_defs.svh"
module reset_and_core_glue_test;
    localparam int COLD = 20;
    logic                        clk, rstn, wdt_reset_req, pll_enable_wr, pll_enable_val, port_func_wr;
    logic                        standby_drive_enable, stop_mode, cold_flag_clr, fault_region_access;
    logic                        mem_fault_enable, in_reset, cold_init, clkgen_reset_flag, pll_active;
    logic                        mem_fault, hard_fault, seen_a, seen_b;
    logic [`RCG_IRQ_NUM-1:0]     irq_src;
    logic [`RCG_DBG_PINS-1:0]    dbg_func_val, dbg_func, dbg_pin_oe;
    logic [`RCG_TRACE_PINS-1:0]  trace_func_val, trace_func;
    logic [31:0]                 aux_fault_status;
    logic [`RCG_INTLINES_W-1:0]  interrupt_line_count_field;
    logic [`RCG_PRIO_BITS_W-1:0] prio_bits;
    logic                        power_good, button_reset, sw_reset_req, slow_mode, core_core_halted_fault_out;
    logic                        pin_low, req_refused;
    logic [63:0]                 rnd;
    int                          miscompares, checks_done, cycles;
    // Reference model of the device's visible state
    int                          exp_dbg, exp_trace, exp_pll, exp_flag, exp_oe;
    int                          pend[$];

    rcg_if lnk_if();
    rcg_device rcg_device_inst (.clk, .rstn, .lnk(lnk_if), .wdt_reset_req, .irq_src, .pll_enable_wr,
        .pll_enable_val, .port_func_wr, .dbg_func_val, .trace_func_val, .standby_drive_enable, .stop_mode,
        .cold_flag_clr, .fault_region_access, .mem_fault_enable, .aux_fault_status, .interrupt_line_count_field,
        .prio_bits, .in_reset, .cold_init, .clkgen_reset_flag, .pll_active, .dbg_func, .trace_func, .dbg_pin_oe,
        .mem_fault, .hard_fault);
    rcg_board #(.COLD_HOLD_CYC(COLD)) rcg_board_inst (.clk, .rstn, .lnk(lnk_if), .power_good, .button_reset,
        .sw_reset_req, .slow_mode, .core_core_halted_fault_out, .pin_low, .req_refused);
    rcg_monitor #(.COLD_HOLD_CYC(COLD)) rcg_monitor_inst (.clk, .rstn, .ext_reset_n(lnk_if.ext_reset_n),
        .core_system_reset_request(lnk_if.core_system_reset_request),
        .core_halted_fault_out(lnk_if.core_halted_fault_out), .core_event_out(lnk_if.core_event_out),
        .deep_sleep_flag(lnk_if.deep_sleep_flag), .core_excl_req(lnk_if.core_excl_req),
        .sys_reset_n(lnk_if.sys_reset_n), .core_event_in(lnk_if.core_event_in),
        .core_excl_okay(lnk_if.core_excl_okay), .core_irq(lnk_if.core_irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole run is under 2000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wait_sys(input logic lvl, input int lim);
        int n;
        n = 0;
        while (lnk_if.sys_reset_n !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        chk("sys_reset_n", lvl, lnk_if.sys_reset_n);
        chk("in_reset", !lvl, in_reset);
    endtask

    task automatic chk_state();
        chk("dbg_func", exp_dbg, dbg_func);
        chk("trace_func", exp_trace, trace_func);
        chk("pll_active", exp_pll, pll_active);
        chk("clkgen_reset_flag", exp_flag, clkgen_reset_flag);
        chk("aux_fault_status", 0, aux_fault_status);
        chk("line_count", 1, interrupt_line_count_field);
        chk("prio_bits", 3, prio_bits);
    endtask

    // Warm reset leaves the cold-only flag alone
    task automatic warm_done(input int lim);
        wait_sys(1'b0, lim);
        wait_sys(1'b1, lim);
        exp_dbg = 'h1f;
        exp_trace = 0;
        exp_pll = 0;
        chk_state();
    endtask

    task automatic cold_reset();
        rstn = 1'b0;
        cyc(4);
        rstn = 1'b1;
        exp_flag = 1;
        cyc(1);
        chk("cold_init", 1, cold_init);
        chk("sys_reset_n", 0, lnk_if.sys_reset_n);
        warm_done(COLD + 40);
    endtask

    // Move state away from reset values so a reset is visible
    task automatic dirty();
        pll_enable_val = 1'b1;
        pll_enable_wr = 1'b1;
        port_func_wr = 1'b1;
        dbg_func_val = 5'h00;
        trace_func_val = 5'h1f;
        cyc(1);
        pll_enable_wr = 1'b0;
        port_func_wr = 1'b0;
        cyc(3);
        exp_pll = 1;
        exp_dbg = 0;
        exp_trace = 'h1f;
        chk_state();
    endtask

    initial begin
        {rstn, wdt_reset_req, pll_enable_wr, pll_enable_val, port_func_wr, standby_drive_enable} = '0;
        {stop_mode, cold_flag_clr, fault_region_access, mem_fault_enable, button_reset, sw_reset_req} = '0;
        {slow_mode, core_core_halted_fault_out, irq_src, dbg_func_val, trace_func_val} = '0;
        power_good = 1'b1;
        void'($urandom(32'hf3e5));
        cold_reset();
        repeat (12) begin
            rnd = {$urandom, $urandom};
            irq_src = rnd[`RCG_IRQ_NUM-1:0];
            {standby_drive_enable, stop_mode, trace_func_val, dbg_func_val} = rnd[63:52];
            pend.push_back(int'(rnd[56:52]));
            pend.push_back(int'(rnd[61:57]));
            port_func_wr = 1'b1;
            cyc(1);
            port_func_wr = 1'b0;
            cyc(3);
            chk("core_irq", {14'h0000, rnd[`RCG_IRQ_NUM-1:0]}, lnk_if.core_irq);
            exp_dbg = pend.pop_front();
            exp_trace = pend.pop_front();
            exp_oe = (stop_mode && !standby_drive_enable) ? (exp_dbg & 'h5) : exp_dbg;
            chk_state();
            chk("dbg_pin_oe", exp_oe, dbg_pin_oe);
        end
        dirty();
        cold_flag_clr = 1'b1;
        cyc(1);
        cold_flag_clr = 1'b0;
        cyc(2);
        exp_flag = 0;
        chk_state();
        wdt_reset_req = 1'b1;
        cyc(2);
        chk("sys_reset_n", 0, lnk_if.sys_reset_n);
        wdt_reset_req = 1'b0;
        warm_done(10);
        dirty();
        button_reset = 1'b1;
        cyc(1);
        button_reset = 1'b0;
        warm_done(40);
        dirty();
        sw_reset_req = 1'b1;
        cyc(1);
        sw_reset_req = 0;
        warm_done(10);
        dirty();
        // Slow-mode request must be refused and leave state intact
        slow_mode = 1'b1;
        sw_reset_req = 1'b1;
        cyc(1);
        sw_reset_req = 1'b0;
        core_core_halted_fault_out = 1'b1;
        seen_a = 1'b0;
        seen_b = 1'b0;
        repeat (20) begin
            seen_a |= req_refused;
            seen_b |= in_reset | ~lnk_if.sys_reset_n;
            cyc(1);
        end
        chk("req_refused", 1, seen_a);
        chk("in_reset", 0, seen_b);
        chk_state();
        {slow_mode, core_core_halted_fault_out} = 2'b00;
        for (int e = 0; e < 2; e++) begin
            mem_fault_enable = e[0];
            fault_region_access = 1'b1;
            cyc(1);
            fault_region_access = 1'b0;
            {seen_a, seen_b} = 2'b00;
            repeat (3) begin
                seen_a |= mem_fault;
                seen_b |= hard_fault;
                cyc(1);
            end
            chk("mem_fault", e, seen_a);
            chk("hard_fault", 1 - e, seen_b);
        end
        power_good = 1'b0;
        cyc(3);
        chk("pin_low", 1, pin_low);
        power_good = 1'b1;
        warm_done(COLD + 40);
        dirty();
        cold_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
